// ==== hdl/eepw_defines.vh ====
// constants for the eeprom page write and busy polling block
// What this block and its bus master do
// R01 - up to 8 bytes programmed in one cycle
// R02 - shorter pages program only received bytes
// R03 - each data byte bumps three low address bits
// R04 - upper address bits hold the row
// R05 - low address wraps to row start
// R06 - master should avoid wrapping inside a row; the bench sends 9 to 14 data bytes to force a wrap
// R07 - write latch flag cleared when cycle ends
// R08 - programming starts at terminating chip select rise
// R09 - status bit 0 shows busy flag
// R10 - while busy only status read is executed
// R11 - master polls status until busy clears
// R12 - write ignored when protected or latch clear
// R13 - master sends opcode, address, then data
// R14 - master avoids block protected addresses
// R15 - busy set at start, held until done
`ifndef EEPW_DEFINES_VH
`define EEPW_DEFINES_VH

// instruction codes
`define EEPW_OP_WRITE_EN 8'h06
`define EEPW_OP_WRITE_DIS 8'h04
`define EEPW_OP_STATUS 8'h05
`define EEPW_OP_READ 8'h03
`define EEPW_OP_WRITE 8'h02
// opcode bit carrying the ninth address bit
`define EEPW_OP_A8_BIT 3
// opcode with the ninth address bit masked off
`define EEPW_OP_MASK 8'hf7

// status bit positions
`define EEPW_ST_BUSY 0
`define EEPW_ST_WLATCH 1

// address layout
`define EEPW_ADDR_W 9
`define EEPW_LOW_W 3
`define EEPW_PAGE_BYTES 8

// self timed program cycle, in microseconds, and clock rate in hz
`define EEPW_PROG_TIME_US 100
`define EEPW_CLK_HZ 10000000

// link phase codes
`define EEPW_PH_OP 3'h0
`define EEPW_PH_ADDR 3'h1
`define EEPW_PH_DATA 3'h2
`define EEPW_PH_RDATA 3'h3
`define EEPW_PH_STAT 3'h4
`define EEPW_PH_WEN 3'h5
`define EEPW_PH_WDIS 3'h6
`define EEPW_PH_IGN 3'h7

`endif

// ==== hdl/eepw_prog_timer.v ====
// self timed program cycle counter with busy level and done pulse
`timescale 1ns/1ns
`default_nettype none
`include "eepw_defines.vh"

module eepw_prog_timer #(
  parameter CYCLES = 1000,
  parameter CNT_W = 16
) (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire start_i,
  output wire busy_o,
  output reg done_o
);

  // ********************************
  // cycle counter
  // ********************************
  reg [CNT_W-1:0] cnt_q; // cycles left in the program cycle
  reg busy_q; // program cycle running

  assign busy_o = busy_q;

  // start is ignored while running; the owner never starts twice
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= {CNT_W{1'b0}};
      busy_q <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      // R15 busy until count expires
      if (start_i && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q <= CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
        // a one cycle program ends at the very next edge
        done_o <= (CYCLES[CNT_W-1:0] == {{(CNT_W-1){1'b0}}, 1'b1});
      end else if (busy_q) begin
        if (cnt_q == {CNT_W{1'b0}}) begin
          busy_q <= 1'b0;
        end else begin
          cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
          // done leads busy by one edge so the owner's latch clears
          // on the same edge that busy drops; status never shows ready
          // with the latch still set
          done_o <= (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== hdl/eepw_top.v ====
// spi eeprom core: page write, self timed program cycle and busy polling
`timescale 1ns/1ns
`default_nettype none
`include "eepw_defines.vh"

module eepw_top #(
  parameter DEPTH = 512,
  parameter PROG_CYCLES = (`EEPW_PROG_TIME_US * (`EEPW_CLK_HZ / 1000000)),
  parameter TIMER_W = 24
) (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire cs_b_i,
  input wire sck_i,
  input wire si_i,
  input wire wp_b_i,
  output reg so_o,
  output reg so_oe_o,
  output wire busy_flag_o,
  output wire write_latch_flag_o
);

  // ********************************
  // pin synchronisers
  // ********************************
  reg cs_b_m, cs_b_s, cs_b_p; // chip select meta, stable, previous
  reg sck_m, sck_s, sck_p; // serial clock meta, stable, previous
  reg si_m, si_s; // serial data in
  reg wp_b_m, wp_b_s; // write protect pin

  // two stages per pin; edge detect only looks at the second stage
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_b_m <= 1'b1;
      cs_b_s <= 1'b1;
      cs_b_p <= 1'b1;
      sck_m <= 1'b0;
      sck_s <= 1'b0;
      sck_p <= 1'b0;
      si_m <= 1'b0;
      si_s <= 1'b0;
      wp_b_m <= 1'b0;
      wp_b_s <= 1'b0;
    end else begin
      cs_b_m <= cs_b_i;
      cs_b_s <= cs_b_m;
      cs_b_p <= cs_b_s;
      sck_m <= sck_i;
      sck_s <= sck_m;
      sck_p <= sck_s;
      si_m <= si_i;
      si_s <= si_m;
      wp_b_m <= wp_b_i;
      wp_b_s <= wp_b_m;
    end
  end

  wire sel = !cs_b_s; // device selected
  wire cs_fall = cs_b_p && !cs_b_s; // frame opens
  wire cs_rise = !cs_b_p && cs_b_s; // frame closes
  wire sck_rise = sel && !sck_p && sck_s; // input sample edge
  wire sck_fall = sel && sck_p && !sck_s; // output shift edge

  // ********************************
  // helpers
  // ********************************
  // next address inside the same row; only the low bits move
  function [`EEPW_ADDR_W-1:0] eepw_row_inc;
    input [`EEPW_ADDR_W-1:0] a;
    begin
      eepw_row_inc = {a[`EEPW_ADDR_W-1:`EEPW_LOW_W],
                      a[`EEPW_LOW_W-1:0] + {{(`EEPW_LOW_W-1){1'b0}}, 1'b1}};
    end
  endfunction

  // status byte as seen on the link
  function [7:0] eepw_status;
    input busy;
    input wlatch;
    begin
      eepw_status = 8'h00;
      eepw_status[`EEPW_ST_BUSY] = busy;
      eepw_status[`EEPW_ST_WLATCH] = wlatch;
    end
  endfunction

  // ********************************
  // link state and storage
  // ********************************
  reg [2:0] ph_q; // frame phase
  reg [2:0] bit_q; // bits taken in the current byte
  reg [6:0] sh_q; // input shift register
  reg [7:0] out_q; // output shift register
  reg rd_q; // address phase belongs to a read
  reg a8_q; // ninth address bit from the opcode
  reg [`EEPW_ADDR_W-1:0] addr_q; // working address
  reg [7:0] buf_q [0:`EEPW_PAGE_BYTES-1]; // page load buffer
  reg [`EEPW_PAGE_BYTES-1:0] mask_q; // buffer slots loaded
  reg wlatch_q; // write latch flag
  reg [7:0] mem [0:DEPTH-1]; // array cells, never reset
  wire busy; // program cycle running
  wire prog_done; // program cycle end pulse
  wire [7:0] rx_byte = {sh_q, si_s}; // byte completed at this edge
  wire byte_end = sck_rise && (bit_q == 3'h7);
  // a frame is a valid page write when it ends on a byte boundary with at least one data byte loaded
  wire wr_start = cs_rise && (ph_q == `EEPW_PH_DATA) && (bit_q == 3'h0) &&
                  (mask_q != {`EEPW_PAGE_BYTES{1'b0}});
  integer i; // slot index of the reset loop
  integer j; // slot index of the commit loop

  assign busy_flag_o = busy;
  assign write_latch_flag_o = wlatch_q;

  // ********************************
  // frame decode
  // ********************************
  // one process walks opcode, address and data bytes
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ph_q <= `EEPW_PH_OP;
      bit_q <= 3'h0;
      sh_q <= 7'h00;
      out_q <= 8'h00;
      rd_q <= 1'b0;
      a8_q <= 1'b0;
      addr_q <= {`EEPW_ADDR_W{1'b0}};
      mask_q <= {`EEPW_PAGE_BYTES{1'b0}};
      for (i = 0; i < `EEPW_PAGE_BYTES; i = i + 1) begin
        buf_q[i] <= 8'h00;
      end
    end else if (cs_fall || !sel) begin
      // every frame starts afresh; abandoned pages are dropped
      ph_q <= `EEPW_PH_OP;
      bit_q <= 3'h0;
      mask_q <= {`EEPW_PAGE_BYTES{1'b0}};
    end else begin
      if (sck_fall) begin
        out_q <= {out_q[6:0], 1'b0};
      end
      if (sck_rise) begin
        sh_q <= rx_byte[6:0];
        bit_q <= bit_q + 3'h1;
      end
      if (byte_end) begin
        case (ph_q)
          `EEPW_PH_OP: begin
            a8_q <= rx_byte[`EEPW_OP_A8_BIT];
            // R10 only status read while busy
            if (busy) begin
              ph_q <= (rx_byte == `EEPW_OP_STATUS) ? `EEPW_PH_STAT : `EEPW_PH_IGN;
            end else if (rx_byte == `EEPW_OP_STATUS) begin
              ph_q <= `EEPW_PH_STAT;
            end else if (rx_byte == `EEPW_OP_WRITE_EN) begin
              ph_q <= `EEPW_PH_WEN;
            end else if (rx_byte == `EEPW_OP_WRITE_DIS) begin
              ph_q <= `EEPW_PH_WDIS;
            end else if ((rx_byte & `EEPW_OP_MASK) == `EEPW_OP_READ) begin
              rd_q <= 1'b1;
              ph_q <= `EEPW_PH_ADDR;
            end else if ((rx_byte & `EEPW_OP_MASK) == `EEPW_OP_WRITE) begin
              rd_q <= 1'b0;
              // R12 protected or latch clear ignores the write
              ph_q <= (wlatch_q && wp_b_s) ? `EEPW_PH_ADDR : `EEPW_PH_IGN;
            end else begin
              ph_q <= `EEPW_PH_IGN;
            end
            if (rx_byte == `EEPW_OP_STATUS) begin
              out_q <= eepw_status(busy, wlatch_q);
            end
          end
          `EEPW_PH_ADDR: begin
            addr_q <= {a8_q, rx_byte};
            if (rd_q) begin
              out_q <= mem[{a8_q, rx_byte}];
              addr_q <= {a8_q, rx_byte} + {{(`EEPW_ADDR_W-1){1'b0}}, 1'b1};
              ph_q <= `EEPW_PH_RDATA;
            end else begin
              ph_q <= `EEPW_PH_DATA;
            end
          end
          `EEPW_PH_DATA: begin
            // R01 bytes gather in the page buffer
            buf_q[addr_q[`EEPW_LOW_W-1:0]] <= rx_byte;
            // R02 only received slots are marked
            mask_q[addr_q[`EEPW_LOW_W-1:0]] <= 1'b1;
            // R03 R04 R05 low bits wrap, row held
            addr_q <= eepw_row_inc(addr_q);
          end
          `EEPW_PH_RDATA: begin
            // sequential read rolls over the whole array
            out_q <= mem[addr_q];
            addr_q <= addr_q + {{(`EEPW_ADDR_W-1){1'b0}}, 1'b1};
          end
          `EEPW_PH_STAT: begin
            // R09 reloaded each byte so polling sees fresh busy
            out_q <= eepw_status(busy, wlatch_q);
          end
          default: begin
            ph_q <= ph_q;
          end
        endcase
      end
    end
  end

  // ********************************
  // array commit
  // ********************************
  // cells take the loaded slots of the row in one go at frame close;
  // unloaded slots keep their old contents
  always @(posedge clk_sys_i) begin
    // R08 R02 commit at terminating select rise
    if (wr_start) begin
      for (j = 0; j < `EEPW_PAGE_BYTES; j = j + 1) begin
        if (mask_q[j]) begin
          mem[{addr_q[`EEPW_ADDR_W-1:`EEPW_LOW_W], j[`EEPW_LOW_W-1:0]}] <= buf_q[j];
        end
      end
    end
  end

  // ********************************
  // write latch
  // ********************************
  // enable and disable take effect only on a clean frame close
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wlatch_q <= 1'b0;
    end else if (prog_done) begin
      // R07 latch cleared at cycle end
      wlatch_q <= 1'b0;
    end else if (cs_rise && bit_q == 3'h0 && ph_q == `EEPW_PH_WEN) begin
      wlatch_q <= 1'b1;
    end else if (cs_rise && bit_q == 3'h0 && ph_q == `EEPW_PH_WDIS) begin
      wlatch_q <= 1'b0;
    end
  end

  // ********************************
  // serial output
  // ********************************
  // data changes on falling clock; driven only in read phases
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
    end else begin
      so_oe_o <= sel && (ph_q == `EEPW_PH_STAT || ph_q == `EEPW_PH_RDATA);
      if (!sel) begin
        so_o <= 1'b0;
      end else if (sck_fall) begin
        so_o <= out_q[7];
      end
    end
  end

  // ********************************
  // program cycle timer
  // ********************************
  // R15 busy raised by the same frame close
  eepw_prog_timer #(
    .CYCLES(PROG_CYCLES),
    .CNT_W(TIMER_W)
  ) u_timer (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .start_i(wr_start),
    .busy_o(busy),
    .done_o(prog_done)
  );

endmodule
`default_nettype wire

// ==== sim/eepw_master.sv ====
// spi bus master model driving mode 0 frames into the eeprom core
`timescale 1ns/1ns
`default_nettype none
module eepw_master (
  input wire logic clk_sys_i,
  input wire logic so_i,
  output logic cs_b_o,
  output logic sck_o,
  output logic si_o
);
  logic [7:0] rx_q [0:15]; // byte seen on so during each byte slot
  initial begin
    cs_b_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end
  // sck period is eight system clocks; sck stands low between frames
  task automatic frame(input logic [7:0] tx [0:15], input int n);
    cs_b_o <= 1'b0;
    for (int b = 0; b < n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        si_o <= tx[b][i];
        repeat (4) @(posedge clk_sys_i);
        sck_o <= 1'b1;
        rx_q[b][i] = so_i;
        repeat (4) @(posedge clk_sys_i);
        sck_o <= 1'b0;
      end
    end
    repeat (4) @(posedge clk_sys_i);
    cs_b_o <= 1'b1;
    // released data line must not keep its last value
    si_o <= ~si_o;
    repeat (8) @(posedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

// ==== sim/eepw_top_sva.sv ====
// assertions on the ports of the eeprom page write core
`timescale 1ns/1ns
`default_nettype none
module eepw_top_sva #(
  parameter PROG_CYCLES = 1000
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic cs_b_i,
  input wire logic wp_b_i,
  input wire logic so_oe_o,
  input wire logic busy_flag_o,
  input wire logic write_latch_flag_o
);
  logic [23:0] busy_cnt_q; // clocks the busy flag has stood high
  // counter restarts whenever busy drops
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_cnt_q <= 24'h0;
    end else if (busy_flag_o) begin
      busy_cnt_q <= busy_cnt_q + 24'h1;
    end else begin
      busy_cnt_q <= 24'h0;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  a_busy_start: assert property ($rose(busy_flag_o) |-> cs_b_i && !$past(cs_b_i, 8))
    else $error("busy rose away from a chip select release");
  a_busy_len: assert property ($fell(busy_flag_o) |-> busy_cnt_q == PROG_CYCLES)
    else $error("busy length wrong");
  a_busy_bound: assert property (busy_flag_o |-> busy_cnt_q < PROG_CYCLES)
    else $error("busy overran");
  a_latch_clear: assert property ($fell(busy_flag_o) |-> !write_latch_flag_o)
    else $error("latch kept after program cycle");
  a_latch_arm: assert property ($rose(busy_flag_o) |-> $past(write_latch_flag_o) && $past(wp_b_i, 6))
    else $error("program started while disabled");
  a_latch_hold: assert property (busy_flag_o && $past(busy_flag_o) |-> $stable(write_latch_flag_o))
    else $error("latch moved while busy");
  a_latch_rise: assert property ($rose(write_latch_flag_o) |-> !$past(busy_flag_o) && cs_b_i)
    else $error("latch set while busy or selected");
  a_oe_select: assert property ($rose(so_oe_o) |-> !cs_b_i)
    else $error("so driven without selection");
  cover property ($rose(busy_flag_o));
  cover property ($rose(write_latch_flag_o));
  cover property ($rose(so_oe_o));
endmodule
`default_nettype wire

// ==== sim/test_eepw_top.sv ====
// self-checking bench for the eeprom page write and busy polling core
`timescale 1ns/1ns
`default_nettype none
module test_eepw_top;
  localparam int PROG_CYCLES = 400; // shortened program cycle
  logic clk_sys_i;
  logic rst_b_i;
  logic wp_b_i;
  wire cs_b, sck, si, so, so_oe, busy, wlatch;
  // an undriven data out line shows the inverse, so a late enable is caught
  wire so_bus = so_oe ? so : ~so;
  int err_count;
  int checks_done;
  logic [7:0] tx [0:15]; // bytes of the next frame
  logic [7:0] mem [0:511]; // expected array contents
  eepw_top #(.PROG_CYCLES(PROG_CYCLES)) DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .cs_b_i(cs_b), .sck_i(sck), .si_i(si), .wp_b_i(wp_b_i), .so_o(so), .so_oe_o(so_oe),
    .busy_flag_o(busy), .write_latch_flag_o(wlatch));
  eepw_master m (.clk_sys_i(clk_sys_i), .so_i(so_bus), .cs_b_o(cs_b), .sck_o(sck), .si_o(si));
  // ************************
  // helpers
  // ************************
  function automatic logic [7:0] exp_status(input logic b, input logic l);
    return {6'h00, l, b};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test;
    if (err_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic send(input logic [7:0] op, input int n);
    tx[0] = op;
    m.frame(tx, n);
  endtask
  // one write attempt, then polling and a readback of the whole row
  task automatic page(input logic [8:0] a, input int n, input logic wp, input logic en);
    logic ok;
    ok = wp & en;
    send(en ? 8'h06 : 8'h04, 1);
    wp_b_i <= wp;
    tx[1] = a[7:0];
    for (int i = 0; i < n; i++) begin
      tx[i + 2] = 8'($urandom);
      if (ok) mem[{a[8:3], a[2:0] + i[2:0]}] = tx[i + 2];
    end
    send(8'h02 | {4'h0, a[8], 3'h0}, n + 2);
    chk("busy_flag", {7'h00, ok}, {7'h00, busy});
    chk("latch_flag", {7'h00, en}, {7'h00, wlatch});
    // a write disable during the cycle must be disregarded
    send(8'h04, 1);
    send(8'h05, 2);
    chk("status_busy", exp_status(ok, ok), m.rx_q[1]);
    for (int k = 0; k < 8 && m.rx_q[1][0] !== 1'b0; k++) send(8'h05, 2);
    chk("status_done", exp_status(1'b0, 1'b0), m.rx_q[1]);
    wp_b_i <= 1'b1;
    tx[1] = {a[7:3], 3'h0};
    send(8'h03 | {4'h0, a[8], 3'h0}, 10);
    for (int i = 0; i < 8; i++) chk("row_byte", mem[{a[8:3], i[2:0]}], m.rx_q[i + 2]);
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // the tests need about 34,000 clocks; this allows 60,000
  initial begin
    #6000000;
    err_count++;
    stop_test();
  end
  initial begin
    logic [8:0] a;
    rst_b_i = 1'b0;
    wp_b_i = 1'b1;
    err_count = 0;
    checks_done = 0;
    void'($urandom(21));
    repeat (12) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk("flags_reset", 8'h00, {6'h00, wlatch, busy});
    send(8'h05, 2);
    chk("status_idle", 8'h00, m.rx_q[1]);
    for (int t = 0; t < 4; t++) begin
      // no block protection is set, so every address is writable
      a = 9'($urandom);
      // full row from its start, no wrap
      page({a[8:3], 3'h0}, 8, 1'b1, 1'b1);
      page(a, 1 + $urandom % 7, 1'b1, 1'b1);
      page(a, 9 + $urandom % 6, 1'b1, 1'b1);
      page(a, 3, 1'b0, 1'b1);
      page(a, 3, 1'b1, 1'b0);
    end
    stop_test();
  end
endmodule
bind eepw_top eepw_top_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (.clk_sys_i(clk_sys_i),
  .rst_b_i(rst_b_i), .cs_b_i(cs_b_i), .wp_b_i(wp_b_i), .so_oe_o(so_oe_o),
  .busy_flag_o(busy_flag_o), .write_latch_flag_o(write_latch_flag_o));
`default_nettype wire
